// ===== rtl/port_dir_pkg.sv
package port_dir_pkg;

    // bus and register widths
    localparam int ADDR_W_MIN = 16;
    localparam int REG_W      = 8;
    localparam int PA_W       = 6;
    localparam int PB_W       = 8;
    localparam int PC_W       = 4;

    // printed register offsets, kept as word indices
    localparam logic [15:0] IDX_PA_DATA = 16'h0000;
    localparam logic [15:0] IDX_PB_DATA = 16'h0001;
    localparam logic [15:0] IDX_PC_DATA = 16'h0002;
    localparam logic [15:0] IDX_PA_OE   = 16'h30B0;
    localparam logic [15:0] IDX_PB_OE   = 16'h30B1;
    localparam logic [15:0] IDX_PC_OE   = 16'h30B2;
    localparam logic [15:0] IDX_PA_IE   = 16'h30B8;

    // byte addresses: four times the index
    localparam logic [15:0] ADDR_PA_DATA = {IDX_PA_DATA[13:0], 2'b00};
    localparam logic [15:0] ADDR_PB_DATA = {IDX_PB_DATA[13:0], 2'b00};
    localparam logic [15:0] ADDR_PC_DATA = {IDX_PC_DATA[13:0], 2'b00};
    localparam logic [15:0] ADDR_PA_OE   = {IDX_PA_OE[13:0], 2'b00};
    localparam logic [15:0] ADDR_PB_OE   = {IDX_PB_OE[13:0], 2'b00};
    localparam logic [15:0] ADDR_PC_OE   = {IDX_PC_OE[13:0], 2'b00};
    localparam logic [15:0] ADDR_PA_IE   = {IDX_PA_IE[13:0], 2'b00};

    // implemented and reserved bit masks
    localparam logic [7:0] PA_OE_MASK = 8'h3F;
    localparam logic [7:0] PB_OE_MASK = 8'hFF;
    localparam logic [7:0] PC_OE_MASK = 8'h0F;
    localparam logic [7:0] PA_IE_MASK = 8'h2F;
    localparam logic [7:0] PA_RSV_OE  = 8'hC0;
    localparam logic [7:0] PC_RSV_OE  = 8'hF0;
    localparam logic [7:0] PA_IE_BIT4 = 8'h10;

    // reset values and lanes
    localparam logic [7:0]  RESET_VAL = 8'h00;
    localparam logic [23:0] UPPER_PAD = 24'h000000;
    localparam int          DATA_LANE = 0;

    typedef enum logic [1:0]
    {
        ST_IDLE   = 2'b01,
        ST_ACCESS = 2'b10
    } apb_state_e;

    typedef struct packed
    {
        logic [7:0] dout;
        logic [7:0] oe;
        logic [7:0] ie;
    } port_pins_s;

endpackage

// ===== rtl/port_pin_cell.sv
`timescale 1ns/1ps

module port_pin_cell #(
    parameter int W = 8
)
(
    input  wire logic [W-1:0]             drive_en,
    input  wire logic [W-1:0]             buffer_en,
    input  wire logic [W-1:0]             data_q,
    input  wire logic [W-1:0]             pin_in,
    output port_dir_pkg::port_pins_s      pins,
    output logic [port_dir_pkg::REG_W-1:0] read_val
);

    logic [W-1:0] live_val;

    generate
        if (W < 1 || W > port_dir_pkg::REG_W)
        begin : g_bad_width
            $error("port_pin_cell: width out of range");
        end
    endgenerate

    // outputs read back the latch, buffered inputs the live pin, unbuffered inputs read zero
    assign live_val = (drive_en & data_q) | (~drive_en & buffer_en & pin_in);

    assign pins.dout = 8'(data_q);
    assign pins.oe   = 8'(drive_en);
    assign pins.ie   = 8'(buffer_en);
    assign read_val  = 8'(live_val);

endmodule

// ===== rtl/port_direction_enables.sv
// Behaviour
// RQ1 - port A drive bits 5..0 switch drivers
// RQ2 - port A bits 7..6 reserved, read zero
// RQ3 - port B eight drive enable bits
// RQ4 - port C drive bits 3..0 switch drivers
// RQ5 - port C bits 7..4 read zero
// RQ6 - port A buffer bits 5,3..0 gate inputs
// RQ7 - enable bits read back last write
// RQ8 - drive enables at three consecutive offsets
// RQ9 - port A buffer enables at own offset
// RQ10 - port A buffer bit 4 reserved zero
// RQ11 - data read: live input, latched output
// RQ12 - reset leaves every pin hi-z input
`timescale 1ns/1ps

module port_direction_enables #(
    parameter int ADDR_W = 16
)
(
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_W-1:0]     paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic [port_dir_pkg::PA_W-1:0] pa_pin_in,
    input  wire logic [port_dir_pkg::PB_W-1:0] pb_pin_in,
    input  wire logic [port_dir_pkg::PC_W-1:0] pc_pin_in,
    output port_dir_pkg::port_pins_s   pa_pins,
    output port_dir_pkg::port_pins_s   pb_pins,
    output port_dir_pkg::port_pins_s   pc_pins
);

    generate
        if (ADDR_W < port_dir_pkg::ADDR_W_MIN)
        begin : g_bad_addr
            $error("port_direction_enables: address too narrow");
        end
    endgenerate

    // address match on the low sixteen bits, upper bits must be zero
    function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [15:0] target);
        addr_is = (a == ADDR_W'(target));
    endfunction

    port_dir_pkg::apb_state_e state_r;
    port_dir_pkg::apb_state_e state_nxt;

    logic [port_dir_pkg::PA_W-1:0] first_port_drive_enable_bits_r;
    logic [port_dir_pkg::PB_W-1:0] second_port_drive_enable_bits_r;
    logic [port_dir_pkg::PC_W-1:0] third_port_drive_enable_bits_r;
    logic [port_dir_pkg::PA_W-1:0] first_port_buffer_enable_bits_r;
    logic [port_dir_pkg::PA_W-1:0] first_port_pin_value_r;
    logic [port_dir_pkg::PB_W-1:0] second_port_pin_value_r;
    logic [port_dir_pkg::PC_W-1:0] third_port_pin_value_r;
    logic [7:0]                    prdata_r;

    logic       sel_pa_data;
    logic       sel_pb_data;
    logic       sel_pc_data;
    logic       sel_pa_oe;
    logic       sel_pb_oe;
    logic       sel_pc_oe;
    logic       sel_pa_ie;
    logic       hit_any;
    logic       setup_phase;
    logic       access_phase;
    logic       wr_en;
    logic       rd_capture;
    logic [7:0] wr_byte;
    logic [7:0] rd_val;
    logic [7:0] pa_read;
    logic [7:0] pb_read;
    logic [7:0] pc_read;
    logic [port_dir_pkg::PA_W-1:0] pa_ie_nxt;

    // address decode, RQ8 drive enables at consecutive words
    assign sel_pa_data = addr_is(paddr, port_dir_pkg::ADDR_PA_DATA);
    assign sel_pb_data = addr_is(paddr, port_dir_pkg::ADDR_PB_DATA);
    assign sel_pc_data = addr_is(paddr, port_dir_pkg::ADDR_PC_DATA);
    assign sel_pa_oe   = addr_is(paddr, port_dir_pkg::ADDR_PA_OE);
    assign sel_pb_oe   = addr_is(paddr, port_dir_pkg::ADDR_PB_OE);
    assign sel_pc_oe   = addr_is(paddr, port_dir_pkg::ADDR_PC_OE);
    // RQ9 buffer enables decoded apart
    assign sel_pa_ie   = addr_is(paddr, port_dir_pkg::ADDR_PA_IE);

    assign hit_any = sel_pa_data | sel_pb_data | sel_pc_data | sel_pa_oe | sel_pb_oe | sel_pc_oe | sel_pa_ie;

    // bus phase tracking
    assign setup_phase  = psel & ~penable;
    assign access_phase = (state_r == port_dir_pkg::ST_ACCESS) & psel & penable;

    always_comb
    begin
        case (state_r)
            port_dir_pkg::ST_IDLE:
                state_nxt = setup_phase ? port_dir_pkg::ST_ACCESS : port_dir_pkg::ST_IDLE;
            port_dir_pkg::ST_ACCESS:
                state_nxt = setup_phase ? port_dir_pkg::ST_ACCESS : port_dir_pkg::ST_IDLE;
            default:
                state_nxt = port_dir_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_r <= port_dir_pkg::ST_IDLE;
        else
            state_r <= state_nxt;
    end

    // zero wait states, unmapped access answers with an error
    assign pready  = (state_r == port_dir_pkg::ST_ACCESS);
    assign pslverr = access_phase & ~hit_any;

    // writes take the low byte lane only
    assign wr_en   = access_phase & pwrite & pstrb[port_dir_pkg::DATA_LANE];
    assign wr_byte = pwdata[7:0];

    // RQ10 bit 4 forced clear, RQ6 bits 5 and 3..0 kept
    assign pa_ie_nxt = port_dir_pkg::PA_W'(wr_byte & port_dir_pkg::PA_IE_MASK);

    // RQ12 reset clears every drive enable and the port A buffer enables, pins come up hi-z
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            first_port_drive_enable_bits_r  <= port_dir_pkg::PA_W'(port_dir_pkg::RESET_VAL);
            second_port_drive_enable_bits_r <= port_dir_pkg::PB_W'(port_dir_pkg::RESET_VAL);
            third_port_drive_enable_bits_r  <= port_dir_pkg::PC_W'(port_dir_pkg::RESET_VAL);
            first_port_buffer_enable_bits_r <= port_dir_pkg::PA_W'(port_dir_pkg::RESET_VAL);
        end
        else if (wr_en)
        begin
            // RQ1 port A drive bits stored
            if (sel_pa_oe)
                first_port_drive_enable_bits_r <= port_dir_pkg::PA_W'(wr_byte & port_dir_pkg::PA_OE_MASK);
            // RQ3 port B all eight bits
            if (sel_pb_oe)
                second_port_drive_enable_bits_r <= port_dir_pkg::PB_W'(wr_byte & port_dir_pkg::PB_OE_MASK);
            // RQ4 port C low nibble
            if (sel_pc_oe)
                third_port_drive_enable_bits_r <= port_dir_pkg::PC_W'(wr_byte & port_dir_pkg::PC_OE_MASK);
            // RQ6 port A buffer bits stored
            if (sel_pa_ie)
                first_port_buffer_enable_bits_r <= pa_ie_nxt;
        end
    end

    // data latches, cleared at reset but not driven while disabled
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            first_port_pin_value_r  <= port_dir_pkg::PA_W'(port_dir_pkg::RESET_VAL);
            second_port_pin_value_r <= port_dir_pkg::PB_W'(port_dir_pkg::RESET_VAL);
            third_port_pin_value_r  <= port_dir_pkg::PC_W'(port_dir_pkg::RESET_VAL);
        end
        else if (wr_en)
        begin
            if (sel_pa_data)
                first_port_pin_value_r <= wr_byte[port_dir_pkg::PA_W-1:0];
            if (sel_pb_data)
                second_port_pin_value_r <= wr_byte[port_dir_pkg::PB_W-1:0];
            if (sel_pc_data)
                third_port_pin_value_r <= wr_byte[port_dir_pkg::PC_W-1:0];
        end
    end

    // RQ11 per-port pin gating and data read selection
    port_pin_cell #(
        .W (port_dir_pkg::PA_W)
    ) u_pa_cell (
        .drive_en  (first_port_drive_enable_bits_r),
        .buffer_en (first_port_buffer_enable_bits_r),
        .data_q    (first_port_pin_value_r),
        .pin_in    (pa_pin_in),
        .pins      (pa_pins),
        .read_val  (pa_read)
    );

    port_pin_cell #(
        .W (port_dir_pkg::PB_W)
    ) u_pb_cell (
        .drive_en  (second_port_drive_enable_bits_r),
        .buffer_en (port_dir_pkg::PB_W'(port_dir_pkg::PB_OE_MASK)),
        .data_q    (second_port_pin_value_r),
        .pin_in    (pb_pin_in),
        .pins      (pb_pins),
        .read_val  (pb_read)
    );

    port_pin_cell #(
        .W (port_dir_pkg::PC_W)
    ) u_pc_cell (
        .drive_en  (third_port_drive_enable_bits_r),
        .buffer_en (port_dir_pkg::PC_W'(port_dir_pkg::PC_OE_MASK)),
        .data_q    (third_port_pin_value_r),
        .pin_in    (pc_pin_in),
        .pins      (pc_pins),
        .read_val  (pc_read)
    );

    // RQ7 read mux returns stored enables, RQ2 RQ5 upper bits zero
    assign rd_val = sel_pa_oe   ? 8'(first_port_drive_enable_bits_r)  :
                    sel_pb_oe   ? 8'(second_port_drive_enable_bits_r) :
                    sel_pc_oe   ? 8'(third_port_drive_enable_bits_r)  :
                    sel_pa_ie   ? 8'(first_port_buffer_enable_bits_r) :
                    sel_pa_data ? pa_read :
                    sel_pb_data ? pb_read :
                    sel_pc_data ? pc_read : port_dir_pkg::RESET_VAL;

    // read data sampled in the setup cycle
    assign rd_capture = setup_phase & ~pwrite;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_r <= port_dir_pkg::RESET_VAL;
        else if (rd_capture)
            prdata_r <= rd_val;
    end

    assign prdata = {port_dir_pkg::UPPER_PAD, prdata_r};

    // checks

    a_pa_drive_follow: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
        (wr_en && sel_pa_oe) |=> (pa_pins.oe[5:0] == $past(pwdata[5:0])))
        else $error("port A drive enables did not follow write");

    a_pa_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
        (pready && psel && !pwrite && (sel_pa_oe || sel_pa_ie)) |-> ((prdata_r & port_dir_pkg::PA_RSV_OE) == 8'h00))
        else $error("port A reserved bits read non-zero");

    a_pb_drive_follow: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
        (wr_en && sel_pb_oe) |=> (pb_pins.oe == $past(pwdata[7:0])))
        else $error("port B drive enables did not follow write");

    a_pc_drive_follow: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
        (wr_en && sel_pc_oe) |=> (pc_pins.oe[3:0] == $past(pwdata[3:0])))
        else $error("port C drive enables did not follow write");

    a_pc_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
        (pready && psel && !pwrite && sel_pc_oe) |-> ((prdata_r & port_dir_pkg::PC_RSV_OE) == 8'h00))
        else $error("port C reserved bits read non-zero");

    a_pa_buffer_follow: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
        (wr_en && sel_pa_ie) |=> (pa_pins.ie == ($past(pwdata[7:0]) & port_dir_pkg::PA_IE_MASK)))
        else $error("port A buffer enables did not follow write");

    a_readback_match: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
        (setup_phase && !pwrite && sel_pb_oe) |=> (prdata_r == $past(pb_pins.oe)))
        else $error("port B enables read back wrong value");

    a_map_decode_b: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
        (wr_en && sel_pb_oe) |=> ($stable(pa_pins.oe) && $stable(pc_pins.oe) && $stable(pa_pins.ie)))
        else $error("port B write disturbed another register");

    a_map_decode_ie: assert property (@(posedge pclk) disable iff (!presetn) // RQ9
        (wr_en && sel_pa_ie) |=> ($stable(pa_pins.oe) && $stable(pb_pins.oe) && $stable(pc_pins.oe)))
        else $error("buffer enable write disturbed drive enables");

    a_unmapped_error: assert property (@(posedge pclk) disable iff (!presetn) // RQ9
        (pready && psel && penable && !hit_any) |-> (pslverr && (pwrite || prdata_r == 8'h00)))
        else $error("unmapped access not answered with error");

    a_ie_bit4_zero: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
        (wr_en && sel_pa_ie && pwdata[4]) |=> ((pa_pins.ie & port_dir_pkg::PA_IE_BIT4) == 8'h00))
        else $error("port A buffer bit 4 was set");

    a_data_read_live: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
        (setup_phase && !pwrite && sel_pa_data) |=>
            (prdata_r[5:0] == (($past(pa_pins.oe[5:0]) & $past(pa_pins.dout[5:0])) |
                               (~$past(pa_pins.oe[5:0]) & $past(pa_pins.ie[5:0]) & $past(pa_pin_in)))))
        else $error("port A data read mixes pins wrongly");

    a_reset_hiz: assert property (@(posedge pclk) disable iff (!presetn) // RQ12
        $rose(presetn) |-> (pa_pins.oe == 8'h00 && pb_pins.oe == 8'h00 && pc_pins.oe == 8'h00 && pa_pins.ie == 8'h00))
        else $error("pins not hi-z after reset");

    a_setup_then_ready: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
        setup_phase |=> pready)
        else $error("setup cycle not followed by ready");

    a_ready_single: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
        !setup_phase |=> !pready)
        else $error("ready raised without a setup cycle");

    a_mapped_no_error: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
        (pready && psel && penable && hit_any) |-> !pslverr)
        else $error("mapped access answered with error");

    a_strobe_ignored: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
        (access_phase && pwrite && !pstrb[port_dir_pkg::DATA_LANE]) |=>
            ($stable(pa_pins.oe) && $stable(pb_pins.oe) && $stable(pc_pins.oe) && $stable(pa_pins.ie)))
        else $error("write with lane 0 off changed an enable");

    a_read_no_change: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
        (access_phase && !pwrite) |=>
            ($stable(pa_pins.oe) && $stable(pb_pins.oe) && $stable(pc_pins.oe) && $stable(pa_pins.ie)))
        else $error("read access changed an enable");

    a_unmapped_no_write: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
        (access_phase && pwrite && !hit_any) |=>
            ($stable(pa_pins.oe) && $stable(pb_pins.oe) && $stable(pc_pins.oe) && $stable(pa_pins.ie)))
        else $error("unmapped write changed an enable");

    a_pa_oe_upper: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
        (wr_en && sel_pa_oe) |=> ((pa_pins.oe & port_dir_pkg::PA_RSV_OE) == 8'h00))
        else $error("port A drive reserved bits set");

    a_pa_ie_upper: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
        (wr_en && sel_pa_ie) |=> ((pa_pins.ie & port_dir_pkg::PA_RSV_OE) == 8'h00))
        else $error("port A buffer reserved bits set");

    a_pc_oe_upper: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
        (wr_en && sel_pc_oe) |=> ((pc_pins.oe & port_dir_pkg::PC_RSV_OE) == 8'h00))
        else $error("port C drive reserved bits set");

    a_pb_read_live: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
        (setup_phase && !pwrite && sel_pb_data) |=>
            (prdata_r == (($past(pb_pins.oe) & $past(pb_pins.dout)) |
                          (~$past(pb_pins.oe) & $past(pb_pin_in)))))
        else $error("port B data read mixes pins wrongly");

    a_pc_read_live: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
        (setup_phase && !pwrite && sel_pc_data) |=>
            (prdata_r == {4'h0, ($past(pc_pins.oe[3:0]) & $past(pc_pins.dout[3:0])) |
                                (~$past(pc_pins.oe[3:0]) & $past(pc_pin_in))}))
        else $error("port C data read mixes pins wrongly");

    a_pa_oe_readback: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
        (setup_phase && !pwrite && sel_pa_oe) |=> (prdata_r == $past(pa_pins.oe)))
        else $error("port A drive enables read back wrong value");

    a_pc_oe_readback: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
        (setup_phase && !pwrite && sel_pc_oe) |=> (prdata_r == $past(pc_pins.oe)))
        else $error("port C drive enables read back wrong value");

    a_pa_ie_readback: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
        (setup_phase && !pwrite && sel_pa_ie) |=> (prdata_r == $past(pa_pins.ie)))
        else $error("port A buffer enables read back wrong value");

    a_pa_data_store: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
        (wr_en && sel_pa_data) |=> (pa_pins.dout == {2'b00, $past(pwdata[5:0])}))
        else $error("port A data latch did not follow write");

    a_reset_data_zero: assert property (@(posedge pclk) disable iff (!presetn) // RQ12
        $rose(presetn) |-> (pa_pins.dout == 8'h00 && pb_pins.dout == 8'h00 && pc_pins.dout == 8'h00))
        else $error("data latches not cleared by reset");

endmodule

// ===== sim/port_direction_enables_tb.sv
`timescale 1ns/1ps

module port_direction_enables_tb;
    logic                      pclk;
    logic                      presetn;
    logic                      psel;
    logic                      penable;
    logic                      pwrite;
    logic [15:0]               paddr;
    logic [31:0]               pwdata;
    logic [3:0]                pstrb;
    logic [31:0]               prdata;
    logic                      pready;
    logic                      pslverr;
    logic [5:0]                pa_pin_in;
    logic [7:0]                pb_pin_in;
    logic [3:0]                pc_pin_in;
    port_dir_pkg::port_pins_s  pa_pins;
    port_dir_pkg::port_pins_s  pb_pins;
    port_dir_pkg::port_pins_s  pc_pins;
    int                        n_errors;
    int                        checks_done;
    logic [31:0]               lfsr;
    logic [7:0]                en_sh[4];
    logic [7:0]                dt_sh[3];
    logic [31:0]               rd;
    logic                      er;
    logic [15:0]               en_addr[4] = '{port_dir_pkg::ADDR_PA_OE, port_dir_pkg::ADDR_PB_OE,
                                              port_dir_pkg::ADDR_PC_OE, port_dir_pkg::ADDR_PA_IE};
    logic [7:0]                en_mask[4] = '{port_dir_pkg::PA_OE_MASK, port_dir_pkg::PB_OE_MASK,
                                              port_dir_pkg::PC_OE_MASK, port_dir_pkg::PA_IE_MASK};
    logic [15:0]               dt_addr[3] = '{port_dir_pkg::ADDR_PA_DATA, port_dir_pkg::ADDR_PB_DATA,
                                              port_dir_pkg::ADDR_PC_DATA};
    logic [15:0]               bad_addr[2] = '{16'hC2CC, 16'h30B0};

    port_direction_enables #(.ADDR_W(16)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pa_pin_in(pa_pin_in), .pb_pin_in(pb_pin_in), .pc_pin_in(pc_pin_in),
        .pa_pins(pa_pins), .pb_pins(pb_pins), .pc_pins(pc_pins));

    always #25 pclk = ~pclk;

    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // output pins echo the latch, inputs the pin level when buffered
    function automatic logic [7:0] exp_data(input logic [7:0] oe, input logic [7:0] dout, input logic [7:0] ie,
                                            input logic [7:0] pin, input logic [7:0] mask);
        return ((oe & dout) | (~oe & ie & pin)) & mask;
    endfunction

    task automatic report_and_stop();
        if (n_errors == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_bit(input string name, input logic exp, input logic got);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                       output logic [31:0] rdata, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic check_regs();
        for (int r = 0; r < 4; r++)
        begin
            apb(1'b0, en_addr[r], 32'h0, 4'h0, rd, er);
            check_val("enable read", {24'h0, en_sh[r] & en_mask[r]}, rd);
            check_bit("enable pslverr", 1'b0, er);
        end
        for (int p = 0; p < 3; p++)
        begin
            apb(1'b0, dt_addr[p], 32'h0, 4'h0, rd, er);
            check_val("data read", {24'h0, exp_data(en_sh[p], dt_sh[p],
                (p == 0) ? en_sh[3] & en_mask[3] : 8'hFF,
                (p == 0) ? {2'b00, pa_pin_in} : (p == 1) ? pb_pin_in : {4'h0, pc_pin_in}, en_mask[p])}, rd);
        end
        @(negedge pclk);
        check_val("port a oe", {24'h0, en_sh[0] & en_mask[0]}, {24'h0, pa_pins.oe});
        check_val("port b oe", {24'h0, en_sh[1]}, {24'h0, pb_pins.oe});
        check_val("port c oe", {24'h0, en_sh[2] & en_mask[2]}, {24'h0, pc_pins.oe});
        check_val("port a ie", {24'h0, en_sh[3] & en_mask[3]}, {24'h0, pa_pins.ie});
        check_val("port a dout", {24'h0, dt_sh[0] & en_mask[0]}, {24'h0, pa_pins.dout});
        check_val("port b dout", {24'h0, dt_sh[1]}, {24'h0, pb_pins.dout});
        check_val("port c dout", {24'h0, dt_sh[2] & en_mask[2]}, {24'h0, pc_pins.dout});
        check_val("port b ie", {24'h0, en_mask[1]}, {24'h0, pb_pins.ie});
        check_val("port c ie", {24'h0, en_mask[2]}, {24'h0, pc_pins.ie});
    endtask

    initial
    begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        report_and_stop();
    end

    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0000;
        pwdata = 32'h0;
        pstrb = 4'h0;
        pa_pin_in = 6'h00;
        pb_pin_in = 8'h00;
        pc_pin_in = 4'h0;
        n_errors = 0;
        checks_done = 0;
        lfsr = 32'h00002C0B;
        en_sh = '{8'h00, 8'h00, 8'h00, 8'h00};
        dt_sh = '{8'h00, 8'h00, 8'h00};
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        check_regs();
        // random and corner enables with reserved bits set
        for (int i = 0; i < 12; i++)
        begin
            for (int r = 0; r < 4; r++)
            begin
                lfsr = lfsr_next(lfsr);
                en_sh[r] = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : lfsr[7:0];
                apb(1'b1, en_addr[r], {lfsr[31:8], en_sh[r]}, 4'hF, rd, er);
            end
            for (int p = 0; p < 3; p++)
            begin
                lfsr = lfsr_next(lfsr);
                dt_sh[p] = lfsr[15:8];
                apb(1'b1, dt_addr[p], {24'h0, dt_sh[p]}, 4'h1, rd, er);
            end
            lfsr = lfsr_next(lfsr);
            pa_pin_in <= lfsr[5:0];
            pb_pin_in <= lfsr[13:6];
            pc_pin_in <= lfsr[17:14];
            check_regs();
        end
        for (int k = 0; k < 2; k++)
        begin
            apb(1'b1, bad_addr[k], 32'hFF, 4'hF, rd, er);
            check_bit("unmapped write err", 1'b1, er);
            apb(1'b0, bad_addr[k], 32'h0, 4'h0, rd, er);
            check_bit("unmapped read err", 1'b1, er);
            check_val("unmapped read", 32'h0, rd);
        end
        apb(1'b1, en_addr[1], {24'h0, ~en_sh[1]}, 4'h0, rd, er);
        check_regs();
        @(posedge pclk);
        presetn <= 1'b0;
        @(negedge pclk);
        check_val("reset pins", 24'h0, {pa_pins.oe, pb_pins.oe, pc_pins.oe});
        check_val("reset a ie", 32'h0, {24'h0, pa_pins.ie});
        @(posedge pclk);
        presetn <= 1'b1;
        en_sh = '{8'h00, 8'h00, 8'h00, 8'h00};
        dt_sh = '{8'h00, 8'h00, 8'h00};
        check_regs();
        report_and_stop();
    end
endmodule
